// File: hw/sbcm_pkg.sv
package sbcm_pkg;
  localparam int CORE_CLK_MHZ = 50;
  // Reset delay after the main rail crosses its reset threshold
  localparam int RESET_DELAY_US = 10;
  localparam int RESET_DELAY_CYC = RESET_DELAY_US * CORE_CLK_MHZ;
  // Continuous filter on the configuration strap
  localparam int STRAP_FILTER_US = 2;
  localparam int STRAP_FILTER_CYC = STRAP_FILTER_US * CORE_CLK_MHZ;
  localparam int LONG_WINDOW_MS = 200;
  localparam int LONG_WINDOW_CYC = LONG_WINDOW_MS * 1000 * CORE_CLK_MHZ;
  localparam int WD_PERIOD_MS = 20;
  localparam int WD_PERIOD_CYC = WD_PERIOD_MS * 1000 * CORE_CLK_MHZ;
  localparam int INT_PULSE_US = 50;
  localparam int INT_PULSE_CYC = INT_PULSE_US * CORE_CLK_MHZ;
  localparam int TMR_W = 24;
  localparam int SPI_WORD_W = 16;
  localparam int SPI_CNT_W = 5;
  localparam logic [4:0] SPI_LAST_BIT = 5'h0F;
  // Command word: address in [6:0], write flag in [7], data in [15:8]
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_ADDR_W = 7;
  localparam int CMD_WRITE_BIT = 7;
  localparam int CMD_DATA_LSB = 8;
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_OUT_CTRL = 7'h02;
  localparam logic [6:0] ADDR_HARDWARE_CONTROL_REG = 7'h03;
  localparam logic [6:0] ADDR_WD_TRIG = 7'h04;
  localparam logic [6:0] ADDR_STAT_CLR = 7'h05;
  // Output control fields
  localparam int OUT_SECOND_REG_BIT = 0;
  localparam int OUT_HIGH_SIDE_BIT = 1;
  localparam int OUT_TRX_BIT = 2;
  // Hardware control fields
  localparam int HW_FAIL_COUNT_BIT = 0;
  localparam int HW_FO_TEST_BIT = 1;
  localparam int HW_OV_RST_BIT = 2;
  localparam logic [2:0] HARDWARE_CONTROL_REG_RST = 3'h0;
  // Status clear fields, one written 1 clears one flag
  localparam int CLR_POR_BIT = 0;
  localparam int CLR_OV_BIT = 1;
  localparam int CLR_UV_BIT = 2;
  localparam int CLR_WD_BIT = 3;
  // Operating mode field codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_SLEEP = 3'h1;
  localparam logic [2:0] MODE_STOP = 3'h2;
  localparam logic [2:0] MODE_SOFT_RESET = 3'h3;
  localparam int SYNC_W = 8;
  typedef enum logic [2:0] {
    SBCM_INIT = 3'b000,
    SBCM_NORMAL = 3'b001,
    SBCM_STOP = 3'b010,
    SBCM_SLEEP = 3'b011,
    SBCM_RESTART = 3'b100,
    SBCM_FAILSAFE = 3'b101
  } sbcm_state_type;
endpackage

// File: hw/sbcm_spi_link.sv
`timescale 1ns/1ns
// Collects one 16-bit frame on the link clock and hands it over by toggle
module sbcm_spi_link (
  input wire logic i_rst_n,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic [15:0] o_word,
  output logic o_word_toggle
);
  logic [15:0] shift_reg;
  logic [4:0] bit_cnt_reg;
  logic frame_last;

  assign frame_last = (bit_cnt_reg == sbcm_pkg::SPI_LAST_BIT);
  // Echo the incoming frame back, a full frame late
  assign o_spi_miso = shift_reg[15];

  // Chip select high ends the frame and rearms the bit counter
  always_ff @(posedge i_spi_sck or posedge i_spi_cs_n) begin
    if (i_spi_cs_n) begin
      bit_cnt_reg <= 5'h00;
    end else if (!bit_cnt_reg[4]) begin
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge i_spi_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_reg <= 16'h0000;
    end else if (!i_spi_cs_n) begin
      shift_reg <= {shift_reg[14:0], i_spi_mosi};
    end
  end

  // Word held stable until the next complete frame
  always_ff @(posedge i_spi_sck or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word <= 16'h0000;
      o_word_toggle <= 1'b0;
    end else if (!i_spi_cs_n && frame_last) begin // see RQ5
      o_word <= {shift_reg[14:0], i_spi_mosi};
      o_word_toggle <= ~o_word_toggle;
    end
  end
endmodule

// File: hw/sbcm_mode_state_machine.sv
`timescale 1ns/1ns
// Summary of operation
// RQ1: Init, normal, stop, sleep, restart, fail-safe; sleep drops main rail.
// RQ2: Restart goes to normal by itself after the reset delay.
// RQ3: Fail-safe holds main rail off until wake or overtemperature ends.
// RQ4: Test strap low at init selects development mode; watchdog halted.
// RQ5: Settings and diagnosis travel in 16-bit frames; controller is master.
// RQ6: Controller writes the mode field; passing through restart clears it.
// RQ7: Power-on starts in init with the watchdog in its long open window.
// RQ8: Strap pulled low and filtered in reset delay, latched on release.
// RQ9: While power-on flag stays set, every reset repeats pull-down and latch.
// RQ10: Unstable strap reads as 0: fail-safe on watchdog failure.
// RQ11: Strap 1: watchdog failure restarts; fail outputs by failure-count bit.
// RQ12: Strap 0: watchdog failure to fail-safe, but first restarts if bit 0.
// RQ13: Overvoltage, reset enabled: flag, fail outputs, restart or fail-safe.
// RQ14: Overvoltage with reset disabled only sets the flag.
// RQ15: Failure-count bit and latched strap are readable.
// RQ16: Latched configuration changes only through a new power-on reset.
// RQ17: Any frame received in init moves the device to normal; the code ignores frames while the reset output is low.
// RQ18: Missing trigger in the long window fails the watchdog into restart; with strap 0 the code goes to fail-safe as in RQ12.
// RQ19: Wake events in init are dropped.
// RQ20: Rail low at power-up: reset low, no undervoltage flag, no fail outputs.
// RQ21: Wake in normal pulses the interrupt pin, mode unchanged.
// RQ22: Entering normal clears output enables; fail outputs default off.
// RQ23: Fail-output test bit drives the fail outputs in normal mode only.
// RQ24: Reset output low on entering restart, released on the move to normal.
// RQ25: Mode field and state codes are freely encoded, transitions kept.
module sbcm_mode_state_machine #(
  parameter int LONG_WINDOW_CYC = sbcm_pkg::LONG_WINDOW_CYC,
  parameter int WD_PERIOD_CYC = sbcm_pkg::WD_PERIOD_CYC,
  parameter int INT_PULSE_CYC = sbcm_pkg::INT_PULSE_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_spi_sck,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  input wire logic i_main_rail_ok,
  input wire logic i_supply_uv,
  input wire logic i_main_rail_ov,
  input wire logic i_overtemp,
  input wire logic i_wake_event,
  input wire logic i_dev_strap_n,
  input wire logic i_int_pin,
  output logic o_int_out,
  output logic o_int_oe,
  output logic o_reset_output,
  output logic [2:0] o_sbc_state,
  output logic [2:0] o_operating_mode_field,
  output logic [2:0] o_hardware_control_reg,
  output logic o_pin_strap_latched,
  output logic o_fail_outputs,
  output logic o_main_regulator_en,
  output logic o_second_regulator_en,
  output logic o_high_side_en,
  output logic o_transceiver_en,
  output logic o_overvoltage_flag,
  output logic o_undervoltage_flag,
  output logic [1:0] o_wd_fail_count,
  output logic o_por_flag,
  output logic o_development_mode
);
  typedef sbcm_pkg::sbcm_state_type sbcm_st_type;

  function automatic logic wr_hit(input logic [15:0] w, input logic [6:0] a);
    wr_hit = w[sbcm_pkg::CMD_WRITE_BIT]
      && (w[sbcm_pkg::CMD_ADDR_LSB +: sbcm_pkg::CMD_ADDR_W] == a);
  endfunction

  logic [15:0] spi_word;
  logic spi_toggle;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic [7:0] prev_reg;
  sbcm_st_type state_reg;
  sbcm_st_type state_next;
  sbcm_st_type fail_target;
  logic ro_reg;
  logic [23:0] rd_cnt_reg;
  logic [23:0] wd_cnt_reg;
  logic wd_long_reg;
  logic [1:0] wd_fail_reg;
  logic fo_reg;
  logic ov_flag_reg;
  logic uv_flag_reg;
  logic por_reg;
  logic strap_reg;
  logic dev_reg;
  logic [23:0] filt_cnt_reg;
  logic filt_val_reg;
  logic [2:0] mode_reg;
  logic [2:0] hw_reg;
  logic [2:0] out_reg;
  logic [23:0] int_cnt_reg;

  sbcm_spi_link u_link (
    .i_rst_n(i_rst_n),
    .i_spi_sck(i_spi_sck),
    .i_spi_cs_n(i_spi_cs_n),
    .i_spi_mosi(i_spi_mosi),
    .o_spi_miso(o_spi_miso),
    .o_word(spi_word),
    .o_word_toggle(spi_toggle)
  );

  // Pins and the link toggle pass two flip-flops before use
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
      prev_reg <= 8'h00;
    end else begin
      sync1_reg <= {spi_toggle, i_int_pin, i_dev_strap_n, i_wake_event,
        i_overtemp, i_main_rail_ov, i_supply_uv, i_main_rail_ok};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  wire rail_ok = sync2_reg[0];
  wire supply_uv = sync2_reg[1];
  wire ov_s = sync2_reg[2];
  wire ot_s = sync2_reg[3];
  wire wake_s = sync2_reg[4];
  wire dev_n_s = sync2_reg[5];
  wire int_s = sync2_reg[6];
  wire spi_evt = sync2_reg[7] ^ prev_reg[7];
  wire ov_rise = ov_s & ~prev_reg[2];
  wire ot_fall = ~ot_s & prev_reg[3];
  wire wake_rise = wake_s & ~prev_reg[4];
  wire int_changed = int_s ^ prev_reg[6];
  wire [7:0] wdata = spi_word[sbcm_pkg::CMD_DATA_LSB +: 8];

  wire st_init = (state_reg == sbcm_pkg::SBCM_INIT);
  wire st_normal = (state_reg == sbcm_pkg::SBCM_NORMAL);
  wire st_stop = (state_reg == sbcm_pkg::SBCM_STOP);
  wire st_restart = (state_reg == sbcm_pkg::SBCM_RESTART);
  wire st_active = st_init | st_normal | st_stop;
  wire ov_rst_en = hw_reg[sbcm_pkg::HW_OV_RST_BIT];
  wire fail_cnt_bit = hw_reg[sbcm_pkg::HW_FAIL_COUNT_BIT];

  // Frames while in restart are not interpreted
  wire spi_ok = spi_evt & ~st_restart;
  wire mode_wr = spi_ok & wr_hit(spi_word, sbcm_pkg::ADDR_MODE_CTRL);
  wire out_wr = spi_ok & st_normal & wr_hit(spi_word, sbcm_pkg::ADDR_OUT_CTRL);
  wire hw_wr = spi_ok & wr_hit(spi_word, sbcm_pkg::ADDR_HARDWARE_CONTROL_REG);
  wire clr_wr = spi_ok & wr_hit(spi_word, sbcm_pkg::ADDR_STAT_CLR);
  wire wd_trig = spi_ok & st_active
    & wr_hit(spi_word, sbcm_pkg::ADDR_WD_TRIG);
  wire [2:0] mode_req = wdata[2:0];

  // Reset delay runs with the rail up while reset is held low
  wire ov_hold = ov_s & ov_rst_en;
  wire rd_run = rail_ok & ~ro_reg & (st_init | (st_restart & ~ov_hold));
  wire rd_done = rd_run
    & (rd_cnt_reg == 24'(sbcm_pkg::RESET_DELAY_CYC - 1));
  wire strap_window = por_reg & rail_ok & ~ro_reg;

  // Watchdog counts only with reset released and outside development mode
  wire wd_run = ro_reg & ~dev_reg & st_active;
  wire [23:0] wd_limit = wd_long_reg ? 24'(LONG_WINDOW_CYC - 1)
    : 24'(WD_PERIOD_CYC - 1);
  wire wd_expire = wd_run & (wd_cnt_reg == wd_limit);
  wire wd_first = (wd_fail_reg == 2'h0);
  wire wd_fo = ~wd_first | fail_cnt_bit;
  wire wd_to_fs = ~strap_reg & ~(wd_first & ~fail_cnt_bit);
  wire ovr_evt = ov_rise & ov_rst_en & ro_reg & st_active;
  wire uv_evt = ro_reg & ~rail_ok & ~supply_uv & (st_normal | st_stop);
  wire fail_go = ovr_evt | wd_expire | uv_evt;
  wire int_start = wake_rise & (st_normal | st_stop);
  wire enter_restart = (state_next == sbcm_pkg::SBCM_RESTART) & ~st_restart;
  wire enter_normal = (state_next == sbcm_pkg::SBCM_NORMAL) & ~st_normal;

  always_comb begin
    if (ovr_evt) begin
      fail_target = strap_reg ? sbcm_pkg::SBCM_RESTART // see RQ13
        : sbcm_pkg::SBCM_FAILSAFE;
    end else if (wd_expire) begin
      fail_target = wd_to_fs ? sbcm_pkg::SBCM_FAILSAFE // see RQ12
        : sbcm_pkg::SBCM_RESTART; // see RQ11
    end else begin
      fail_target = sbcm_pkg::SBCM_RESTART;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      sbcm_pkg::SBCM_INIT: begin
        if (fail_go) begin
          state_next = fail_target; // see RQ18
        end else if (spi_ok & ro_reg) begin
          state_next = sbcm_pkg::SBCM_NORMAL; // see RQ17
        end
      end
      sbcm_pkg::SBCM_NORMAL: begin
        if (fail_go) begin
          state_next = fail_target;
        end else if (mode_wr & (mode_req == sbcm_pkg::MODE_SLEEP)) begin
          state_next = sbcm_pkg::SBCM_SLEEP; // see RQ6
        end else if (mode_wr & (mode_req == sbcm_pkg::MODE_STOP)) begin
          state_next = sbcm_pkg::SBCM_STOP;
        end else if (mode_wr & (mode_req == sbcm_pkg::MODE_SOFT_RESET)) begin
          state_next = sbcm_pkg::SBCM_INIT;
        end
      end
      sbcm_pkg::SBCM_STOP: begin
        if (fail_go) begin
          state_next = fail_target;
        end else if (mode_wr & (mode_req == sbcm_pkg::MODE_NORMAL)) begin
          state_next = sbcm_pkg::SBCM_NORMAL;
        end else if (mode_wr & (mode_req == sbcm_pkg::MODE_SLEEP)) begin
          state_next = sbcm_pkg::SBCM_RESTART;
        end else if (mode_wr & (mode_req == sbcm_pkg::MODE_SOFT_RESET)) begin
          state_next = sbcm_pkg::SBCM_INIT;
        end
      end
      sbcm_pkg::SBCM_SLEEP: begin
        if (wake_rise) begin
          state_next = sbcm_pkg::SBCM_RESTART;
        end
      end
      sbcm_pkg::SBCM_RESTART: begin
        if (rd_done) begin
          state_next = sbcm_pkg::SBCM_NORMAL; // see RQ2
        end
      end
      sbcm_pkg::SBCM_FAILSAFE: begin
        if (wake_rise | ot_fall) begin
          state_next = sbcm_pkg::SBCM_RESTART; // see RQ3
        end
      end
      default: state_next = sbcm_pkg::SBCM_INIT;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= sbcm_pkg::SBCM_INIT; // see RQ7
    end else begin
      state_reg <= state_next; // see RQ1
    end
  end

  // Reset output and reset delay
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ro_reg <= 1'b0;
      rd_cnt_reg <= 24'h000000;
    end else begin
      rd_cnt_reg <= rd_run ? rd_cnt_reg + 24'h000001 : 24'h000000;
      if (!rail_ok | enter_restart) begin
        ro_reg <= 1'b0; // see RQ20, RQ24
      end else if (rd_done) begin
        ro_reg <= 1'b1;
      end
    end
  end

  // Strap filter: any change discards the level, so unstable reads as 0
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      filt_cnt_reg <= 24'h000000;
      filt_val_reg <= 1'b0;
    end else if (!strap_window | int_changed) begin
      filt_cnt_reg <= 24'h000000; // see RQ8
      filt_val_reg <= 1'b0; // see RQ10
    end else if (filt_cnt_reg
        == 24'(sbcm_pkg::STRAP_FILTER_CYC - 1)) begin
      filt_val_reg <= int_s;
    end else begin
      filt_cnt_reg <= filt_cnt_reg + 24'h000001;
    end
  end

  // Configuration caught on the rising edge of the reset output
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_reg <= 1'b0;
      dev_reg <= 1'b0;
    end else if (rd_done & por_reg) begin
      strap_reg <= filt_val_reg; // see RQ9, RQ16
      if (st_init) begin
        dev_reg <= ~dev_n_s; // see RQ4
      end
    end
  end

  // Watchdog
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_cnt_reg <= 24'h000000;
      wd_long_reg <= 1'b1;
    end else if (rd_done
        | ((state_next == sbcm_pkg::SBCM_INIT) & ~st_init)) begin
      wd_cnt_reg <= 24'h000000;
      wd_long_reg <= 1'b1; // see RQ7
    end else if (wd_trig) begin
      wd_cnt_reg <= 24'h000000; // see RQ18
      wd_long_reg <= 1'b0;
    end else if (!wd_run | wd_expire) begin
      wd_cnt_reg <= 24'h000000; // see RQ4
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 24'h000001;
    end
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wd_fail_reg <= 2'h0;
      fo_reg <= 1'b0;
      ov_flag_reg <= 1'b0;
      uv_flag_reg <= 1'b0;
      por_reg <= 1'b1;
    end else begin
      if (wd_expire) begin
        wd_fail_reg <= wd_first ? 2'h1 : 2'h2;
      end else if (clr_wr & wdata[sbcm_pkg::CLR_WD_BIT]) begin
        wd_fail_reg <= 2'h0;
      end
      if ((wd_expire & wd_fo) | ovr_evt) begin
        fo_reg <= 1'b1; // see RQ11, RQ13
      end
      if (ov_rise) begin
        ov_flag_reg <= 1'b1; // see RQ14
      end else if (clr_wr & wdata[sbcm_pkg::CLR_OV_BIT]) begin
        ov_flag_reg <= 1'b0;
      end
      if (uv_evt) begin
        uv_flag_reg <= 1'b1; // see RQ20
      end else if (clr_wr & wdata[sbcm_pkg::CLR_UV_BIT]) begin
        uv_flag_reg <= 1'b0;
      end
      if (clr_wr & wdata[sbcm_pkg::CLR_POR_BIT]) begin
        por_reg <= 1'b0;
      end
    end
  end

  // Mode field, hardware control and output control
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_reg <= sbcm_pkg::MODE_NORMAL;
      hw_reg <= sbcm_pkg::HARDWARE_CONTROL_REG_RST;
      out_reg <= 3'h0;
    end else begin
      if (enter_restart) begin
        mode_reg <= sbcm_pkg::MODE_NORMAL; // see RQ6
      end else if (mode_wr & (st_normal | st_stop)) begin
        mode_reg <= mode_req;
      end
      if (hw_wr) begin
        hw_reg <= wdata[2:0];
      end
      if (enter_normal) begin
        out_reg <= 3'h0; // see RQ22
      end else if (out_wr) begin
        out_reg <= wdata[2:0];
      end
    end
  end

  // Interrupt pulse on wake; init never starts one
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_cnt_reg <= 24'h000000;
    end else if (int_start) begin
      int_cnt_reg <= 24'(INT_PULSE_CYC); // see RQ21, RQ19
    end else if (int_cnt_reg != 24'h000000) begin
      int_cnt_reg <= int_cnt_reg - 24'h000001;
    end
  end

  assign o_int_out = 1'b0;
  assign o_int_oe = strap_window | (int_cnt_reg != 24'h000000);
  assign o_reset_output = ro_reg;
  assign o_sbc_state = state_reg; // see RQ25
  assign o_operating_mode_field = mode_reg;
  assign o_hardware_control_reg = hw_reg; // see RQ15
  assign o_pin_strap_latched = strap_reg;
  assign o_fail_outputs = fo_reg
    | (st_normal & hw_reg[sbcm_pkg::HW_FO_TEST_BIT]); // see RQ23
  assign o_main_regulator_en = ~((state_reg == sbcm_pkg::SBCM_SLEEP)
    | (state_reg == sbcm_pkg::SBCM_FAILSAFE));
  assign o_second_regulator_en = out_reg[sbcm_pkg::OUT_SECOND_REG_BIT];
  assign o_high_side_en = out_reg[sbcm_pkg::OUT_HIGH_SIDE_BIT];
  assign o_transceiver_en = out_reg[sbcm_pkg::OUT_TRX_BIT];
  assign o_overvoltage_flag = ov_flag_reg;
  assign o_undervoltage_flag = uv_flag_reg;
  assign o_wd_fail_count = wd_fail_reg;
  assign o_por_flag = por_reg;
  assign o_development_mode = dev_reg;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_restart_ro;
    enter_restart |=> !o_reset_output throughout (st_restart [*2]);
  endproperty
  a_restart_ro: assert property (p_restart_ro) // see RQ24
    else $error("reset output high in restart");
  property p_restart_exit;
    st_restart && rd_done |=> st_normal && o_reset_output;
  endproperty
  a_restart_exit: assert property (p_restart_exit) // see RQ2
    else $error("restart exit");
  property p_failsafe_reg;
    state_reg == sbcm_pkg::SBCM_FAILSAFE |-> !o_main_regulator_en;
  endproperty
  a_failsafe_reg: assert property (p_failsafe_reg) // see RQ3
    else $error("regulator on");
  property p_init_spi;
    st_init && spi_evt && ro_reg && !fail_go |=> st_normal;
  endproperty
  a_init_spi: assert property (p_init_spi) // see RQ17
    else $error("init not left");
  property p_init_wake;
    st_init && int_cnt_reg == 24'h000000 |=> int_cnt_reg == 24'h000000;
  endproperty
  a_init_wake: assert property (p_init_wake) // see RQ19
    else $error("wake in init");
  property p_ov_norst;
    ov_rise && !ov_rst_en && !wd_expire && !fo_reg
      |=> o_overvoltage_flag && !fo_reg;
  endproperty
  a_ov_norst: assert property (p_ov_norst) // see RQ14
    else $error("ov reaction");
  property p_strap_keep;
    !por_reg |=> $stable(strap_reg);
  endproperty
  a_strap_keep: assert property (p_strap_keep) // see RQ16
    else $error("strap changed");
  property p_rail_low;
    !rail_ok |=> !o_reset_output;
  endproperty
  a_rail_low: assert property (p_rail_low) // see RQ20
    else $error("reset output high with rail low");
  property p_wd_restart;
    wd_expire && strap_reg && !ovr_evt |=> st_restart ##1 !o_reset_output;
  endproperty
  a_wd_restart: assert property (p_wd_restart) // see RQ11
    else $error("wd restart");
  property p_dev_halt;
    dev_reg |=> wd_cnt_reg == 24'h000000;
  endproperty
  a_dev_halt: assert property (p_dev_halt) // see RQ4
    else $error("wd runs in dev");

  c_restart_normal: cover property (st_restart ##1 st_normal);
  c_failsafe: cover property (wd_expire
    ##1 state_reg == sbcm_pkg::SBCM_FAILSAFE);
  c_ov_reset: cover property (ovr_evt ##1 fo_reg);
endmodule

// File: testbench/sbcm_spi_master.sv
`timescale 1ns/1ns
// Controller side of the link: one 16-bit frame per rising edge of i_go
module sbcm_spi_master (
  input wire logic i_go,
  input wire logic [15:0] i_word,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_mosi,
  output logic o_busy
);
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
    o_busy = 1'b0;
  end
  // Clock stands still outside frames; 12 ns period within them
  always @(posedge i_go) begin
    o_busy = 1'b1;
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = i_word[i];
      #6 o_sck = 1'b1;
      #6 o_sck = 1'b0;
    end
    #6 o_cs_n = 1'b1;
    // Released data line must not keep the last bit
    o_mosi = ~o_mosi;
    #200 o_busy = 1'b0;
  end
endmodule

// File: testbench/operating_mode_field_state_machine_tb.sv
`timescale 1ns/1ns
module operating_mode_field_state_machine_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rail_ok = 1'b0;
  logic [1:0] ev = 2'h0;
  logic dev_n = 1'b1;
  logic ext_pu = 1'b1;
  logic go = 1'b0;
  logic [15:0] word = 16'h0000;
  logic sck, cs_n, mosi, busy, int_oe, ro, strap, fo, mreg, ovf, por, dev;
  logic [2:0] st, mf, hw;
  logic sreg, hs, trx, uvf;
  logic [1:0] wdc;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  sbcm_spi_master i_mst (.i_go(go), .i_word(word), .o_sck(sck),
    .o_cs_n(cs_n), .o_mosi(mosi), .o_busy(busy));
  sbcm_mode_state_machine #(.LONG_WINDOW_CYC(2000), .WD_PERIOD_CYC(1000),
    .INT_PULSE_CYC(50)) i_dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_spi_sck(sck), .i_spi_cs_n(cs_n), .i_spi_mosi(mosi), .o_spi_miso(),
    .i_main_rail_ok(rail_ok), .i_supply_uv(1'b0), .i_main_rail_ov(ev[1]),
    .i_overtemp(1'b0), .i_wake_event(ev[0]), .i_dev_strap_n(dev_n),
    .i_int_pin(ext_pu), .o_int_out(), .o_int_oe(int_oe),
    .o_reset_output(ro), .o_sbc_state(st), .o_operating_mode_field(mf),
    .o_hardware_control_reg(hw), .o_pin_strap_latched(strap),
    .o_fail_outputs(fo), .o_main_regulator_en(mreg),
    .o_second_regulator_en(sreg), .o_high_side_en(hs),
    .o_transceiver_en(trx), .o_overvoltage_flag(ovf),
    .o_undervoltage_flag(uvf), .o_wd_fail_count(wdc),
    .o_por_flag(por), .o_development_mode(dev));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [15:0] w);
    @(posedge clk);
    word <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge clk);
    repeat (10) @(negedge clk);
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    repeat (8) @(posedge clk);
    ev[b] <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_st(input logic [2:0] exp, input int lim);
    for (int i = 0; i < lim && st !== exp; i++) @(negedge clk);
    chk({5'h00, st}, {5'h00, exp});
  endtask
  task automatic power_up();
    @(posedge clk);
    rst_n <= 1'b0;
    rail_ok <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rail_ok <= 1'b1;
    @(negedge clk);
  endtask
  task automatic wait_ro();
    for (int i = 0; i < 700 && ro !== 1'b1; i++) @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    power_up();
    chk({2'h0, uvf, ro, por, st}, 8'h08);
    pulse(0);
    wait_ro();
    chk({3'h0, ro, strap, st}, 8'h18);
    $display("end of test: power-up");
    send(16'h0583);
    chk({fo, mreg, hw, st}, 8'h69);
    send(16'h0782);
    chk({5'h00, sreg, hs, trx}, 8'h07);
    send(16'h0185);
    pulse(0);
    chk({3'h0, int_oe, por, st}, 8'h11);
    send(16'h0281);
    chk({2'h0, mf, st}, 8'h12);
    @(posedge clk);
    ext_pu <= 1'b0;
    wait_st(3'h4, 3000);
    chk({6'h00, fo, ro}, 8'h02);
    wait_st(3'h1, 700);
    chk({3'h0, mf, ro, strap}, 8'h03);
    chk({3'h0, wdc, sreg, hs, trx}, 8'h08);
    $display("end of test: watchdog restart");
    send(16'h0183);
    pulse(1);
    repeat (6) @(negedge clk);
    chk({4'h0, ovf, st}, 8'h09);
    send(16'h0285);
    send(16'h0583);
    pulse(1);
    wait_st(3'h4, 20);
    chk({6'h00, ovf, fo}, 8'h03);
    $display("end of test: overvoltage");
    power_up();
    wait_ro();
    chk({5'h00, por, strap, dev}, 8'h04);
    send(16'h0084);
    send(16'h0283);
    chk({7'h00, fo}, 8'h01);
    send(16'h0083);
    chk({7'h00, fo}, 8'h00);
    wait_st(3'h4, 1500);
    chk({7'h00, fo}, 8'h00);
    wait_st(3'h1, 700);
    wait_st(3'h5, 2600);
    chk({6'h00, fo, mreg}, 8'h02);
    pulse(0);
    wait_st(3'h4, 20);
    $display("end of test: fail-safe");
    @(posedge clk);
    dev_n <= 1'b0;
    power_up();
    wait_ro();
    chk({7'h00, dev}, 8'h01);
    repeat (2500) @(negedge clk);
    chk({5'h00, st}, 8'h00);
    $display("end of test: development");
    close_out();
  end
endmodule
